// >>> logic/sxd_slot_decode.sv
// host-side slot address decoder: strobes, selects, scratch protection, bank switch
// assumes address and valid sampled on clk, synchronous to the processor cycle
`timescale 1ns/1ps
module sxd_slot_decode
   import sxd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // processor bus
   input wire logic [15:0] addr,
   input wire logic addr_valid,
   input wire logic rd_wr_n,
   input wire logic char_out_active,
   // slot strobes
   output logic expansion_window_strobe_n,
   output logic [7:1] slot_rom_page_select_n,
   output logic [7:1] slot_io_window_select_n,
   // memory control
   output logic scratch_hit,
   output logic [2:0] scratch_slot,
   output logic scratch_display_blank,
   output logic scratch_write_block,
   output logic bank2_select,
   output logic bank2_read_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // decode functions

   // picks a three-bit slot number out of an address at the given position
   function automatic logic [2:0] slot_field(input logic [15:0] a, input int lsb);
      logic [2:0] n;
      n = a[lsb +: 3];
      return n;
   endfunction

   // one high bit per slot 1 to 7; slot 0 gives no bit
   function automatic logic [7:1] slot_onehot(input logic [2:0] n);
      logic [7:0] v;
      v = 8'h01 << n;
      return v[7:1];
   endfunction

   // shared expansion window, disable location included
   function automatic logic in_expansion_window(input logic [15:0] a);
      logic hit;
      hit = 1'h0;
      if (a >= SXD_EXP_LO && a <= SXD_EXP_HI) begin
         hit = 1'h1;
      end
      return hit;
   endfunction

   // i/o locations of slots 1 to 7; the slot 0 block is left to the soft switches
   function automatic logic in_slot_io(input logic [15:0] a);
      logic hit;
      hit = 1'h0;
      if (a >= (SXD_IO_BASE + 16'(SXD_IO_PER_SLOT)) && a <= SXD_IO_LAST) begin
         hit = 1'h1;
      end
      return hit;
   endfunction

   // one 256-byte rom page per slot, pages c1 to c7
   function automatic logic in_slot_rom(input logic [15:0] a);
      logic hit;
      hit = 1'h0;
      if (a[15:8] >= SXD_ROM_PAGE_HI && a[15:8] <= SXD_ROM_PAGE_TOP) begin
         hit = 1'h1;
      end
      return hit;
   endfunction

   // slot scratch bytes: base plus slot 1 to 7, bases xx78 and xxf8 in pages 04 to 07
   // the base bytes themselves belong to no slot and are left alone
   function automatic logic is_scratch(input logic [15:0] a);
      logic hit;
      hit = 1'h0;
      if (a >= SXD_SCRATCH_FIRST && a <= (SXD_SCRATCH_LAST + SXD_SCRATCH_SPAN)) begin
         if (a[SXD_SCRATCH_TAG_LSB +: 4] == SXD_SCRATCH_TAG) begin
            if (slot_field(a, SXD_SCRATCH_SLOT_LSB) != SXD_SLOT_NONE) begin
               hit = 1'h1;
            end
         end
      end
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next values from the current access

   logic strobe_next;
   logic [7:1] io_select_next;
   logic [7:1] rom_select_next;
   logic scratch_hit_next;
   logic [2:0] scratch_slot_next;
   logic write_block_next;
   logic bank2_hit;

   // expansion strobe: low for any valid access inside the window
   always_comb begin
      strobe_next = SXD_STROBE_IDLE;
      if (addr_valid && in_expansion_window(addr)) begin
         strobe_next = 1'h0;
      end
   end

   // i/o select: the slot number sits in the nibble above the four card lines
   always_comb begin
      io_select_next = SXD_SELECT_IDLE;
      if (addr_valid && in_slot_io(addr)) begin
         io_select_next = ~slot_onehot(slot_field(addr, SXD_IO_SLOT_LSB));
      end
   end

   // rom select: the slot number is the low digit of the page
   always_comb begin
      rom_select_next = SXD_SELECT_IDLE;
      if (addr_valid && in_slot_rom(addr)) begin
         rom_select_next = ~slot_onehot(slot_field(addr, SXD_ROM_SLOT_LSB));
      end
   end

   // scratch byte hit and its owning slot
   always_comb begin
      scratch_hit_next = 1'h0;
      scratch_slot_next = SXD_SLOT_NONE;
      if (addr_valid && is_scratch(addr)) begin
         scratch_hit_next = 1'h1;
         scratch_slot_next = slot_field(addr, SXD_SCRATCH_SLOT_LSB);
      end
   end

   // writes by the character output routine must not reach a scratch byte
   always_comb begin
      write_block_next = 1'h0;
      if (scratch_hit_next && char_out_active && !rd_wr_n) begin
         write_block_next = 1'h1;
      end
   end

   // the slot 0 i/o base is the second-bank soft switch
   always_comb begin
      bank2_hit = 1'h0;
      if (addr_valid && addr == SXD_BANK2_SWITCH) begin
         bank2_hit = 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs

   logic strobe_reg;
   logic [7:1] io_select_reg;
   logic [7:1] rom_select_reg;
   logic scratch_hit_reg;
   logic [2:0] scratch_slot_reg;
   logic display_blank_reg;
   logic write_block_reg;
   logic bank2_select_reg;
   logic bank2_read_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         strobe_reg <= SXD_STROBE_IDLE;
      end else begin
         strobe_reg <= strobe_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         io_select_reg <= SXD_SELECT_IDLE;
      end else begin
         io_select_reg <= io_select_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rom_select_reg <= SXD_SELECT_IDLE;
      end else begin
         rom_select_reg <= rom_select_next;
      end
   end

   // scratch hit and slot
   always_ff @(posedge clk) begin
      if (reset) begin
         scratch_hit_reg <= SXD_FLAG_RESET;
         scratch_slot_reg <= SXD_SLOT_NONE;
      end else begin
         scratch_hit_reg <= scratch_hit_next;
         scratch_slot_reg <= scratch_slot_next;
      end
   end

   // video blanking follows every scratch hit
   always_ff @(posedge clk) begin
      if (reset) begin
         display_blank_reg <= SXD_FLAG_RESET;
      end else begin
         display_blank_reg <= scratch_hit_next;
      end
   end

   // write block for the character output routine
   always_ff @(posedge clk) begin
      if (reset) begin
         write_block_reg <= SXD_FLAG_RESET;
      end else begin
         write_block_reg <= write_block_next;
      end
   end

   // soft switch: sticky until reset; other bank switches live outside this block
   always_ff @(posedge clk) begin
      if (reset) begin
         bank2_select_reg <= SXD_BANK2_RESET;
         bank2_read_reg <= SXD_BANK2_RESET;
      end else if (bank2_hit) begin
         bank2_select_reg <= 1'h1;
         bank2_read_reg <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port drivers

   assign expansion_window_strobe_n = strobe_reg;
   assign slot_io_window_select_n = io_select_reg;
   assign slot_rom_page_select_n = rom_select_reg;
   assign scratch_hit = scratch_hit_reg;
   assign scratch_slot = scratch_slot_reg;
   assign scratch_display_blank = display_blank_reg;
   assign scratch_write_block = write_block_reg;
   assign bank2_select = bank2_select_reg;
   assign bank2_read_enable = bank2_read_reg;

endmodule

// >>> logic/sxd_pkg.sv
// package for the slot expansion decode block
// assumes a 16-bit processor address bus and seven peripheral slots
package sxd_pkg;
   localparam logic [15:0] SXD_EXP_LO = 16'hc800;
   localparam logic [15:0] SXD_EXP_HI = 16'hcfff;
   localparam logic [15:0] SXD_EXP_DISABLE = 16'hcfff;
   localparam logic [15:0] SXD_IO_BASE = 16'hc080;
   localparam logic [15:0] SXD_IO_LAST = 16'hc0ff;
   localparam logic [7:0] SXD_ROM_PAGE_HI = 8'hc1;
   localparam logic [7:0] SXD_ROM_PAGE_TOP = 8'hc7;
   localparam logic [15:0] SXD_BANK2_SWITCH = 16'hc080;
   localparam logic [15:0] SXD_BANK2_BASE = 16'hd000;
   localparam logic [15:0] SXD_OWNER_SLOT_ADDR = 16'h07f8;
   localparam logic [15:0] SXD_SCRATCH_FIRST = 16'h0478;
   localparam logic [15:0] SXD_SCRATCH_LAST = 16'h07f8;
   localparam int SXD_SCRATCH_BYTES = 56;
   localparam int SXD_SCRATCH_PER_SLOT = 8;
   localparam int SXD_IO_PER_SLOT = 16;
   localparam int SXD_SLOTS = 7;
   localparam logic SXD_BANK2_RESET = 1'h0;
   // address field positions
   localparam int SXD_IO_SLOT_LSB = 4;
   localparam int SXD_ROM_SLOT_LSB = 8;
   localparam int SXD_SCRATCH_SLOT_LSB = 0;
   localparam int SXD_SCRATCH_TAG_LSB = 3;
   localparam logic [3:0] SXD_SCRATCH_TAG = 4'hf;
   localparam logic [15:0] SXD_SCRATCH_SPAN = 16'h0007;
   // reset and idle values of the registered outputs
   localparam logic SXD_STROBE_IDLE = 1'h1;
   localparam logic [7:1] SXD_SELECT_IDLE = 7'h7f;
   localparam logic [2:0] SXD_SLOT_NONE = 3'h0;
   localparam logic SXD_FLAG_RESET = 1'h0;
endpackage

// >>> test/sxd_slot_decode_checker.sv
// port checker for the slot decoder
// assumes it is bound onto sxd_slot_decode, one clock, synchronous reset
`timescale 1ns/1ps
module sxd_slot_decode_checker import sxd_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // processor bus
   input wire logic [15:0] addr,
   input wire logic addr_valid,
   input wire logic rd_wr_n,
   input wire logic char_out_active,
   // slot strobes
   input wire logic expansion_window_strobe_n,
   input wire logic [7:1] slot_rom_page_select_n,
   input wire logic [7:1] slot_io_window_select_n,
   // memory control
   input wire logic scratch_hit,
   input wire logic [2:0] scratch_slot,
   input wire logic scratch_display_blank,
   input wire logic scratch_write_block,
   input wire logic bank2_select,
   input wire logic bank2_read_enable);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_exp_strobe: assert property (addr_valid |=>
      expansion_window_strobe_n == !$past(addr[15:11] == 5'h19)) else $error("strobe");
   a_io_select: assert property (addr_valid && addr[15:7] == 9'h181 && addr[6:4] != 3'h0 |=>
      slot_io_window_select_n == ~(7'h01 << ($past(addr[6:4]) - 3'h1))) else $error("io select");
   a_rom_select: assert property (addr_valid && addr[15:11] == 5'h18 && addr[10:8] != 3'h0 |=>
      slot_rom_page_select_n == ~(7'h01 << ($past(addr[10:8]) - 3'h1))) else $error("rom select");
   a_idle_quiet: assert property (!addr_valid |=>
      expansion_window_strobe_n && &slot_rom_page_select_n && &slot_io_window_select_n) else $error("idle");
   a_scratch_slot: assert property (addr_valid && addr[15:10] == 6'h01 && addr[6:3] == 4'hf |=>
      scratch_hit == ($past(addr[2:0]) != 3'h0) && scratch_slot == $past(addr[2:0])) else $error("scratch");
   a_scratch_guard: assert property (scratch_write_block |->
      scratch_display_blank && $past(char_out_active) && !$past(rd_wr_n)) else $error("guard");
   a_write_block: assert property (addr_valid && addr[15:10] == 6'h01 && addr[6:3] == 4'hf &&
      addr[2:0] != 3'h0 && char_out_active && !rd_wr_n |=> scratch_write_block) else $error("write block");
   a_bank_switch: assert property (addr_valid && addr == SXD_BANK2_SWITCH |=>
      bank2_select && bank2_read_enable ##1 bank2_select) else $error("bank");
   c_disable: cover property (addr_valid && addr == SXD_EXP_DISABLE);
   c_block: cover property (scratch_write_block);
   c_bank: cover property ($rose(bank2_select));
endmodule
bind sxd_slot_decode sxd_slot_decode_checker i_chk (
   .clk(clk),
   .reset(reset),
   .addr(addr),
   .addr_valid(addr_valid),
   .rd_wr_n(rd_wr_n),
   .char_out_active(char_out_active),
   .expansion_window_strobe_n(expansion_window_strobe_n),
   .slot_rom_page_select_n(slot_rom_page_select_n),
   .slot_io_window_select_n(slot_io_window_select_n),
   .scratch_hit(scratch_hit),
   .scratch_slot(scratch_slot),
   .scratch_display_blank(scratch_display_blank),
   .scratch_write_block(scratch_write_block),
   .bank2_select(bank2_select),
   .bank2_read_enable(bank2_read_enable)
);

// >>> test/sxd_card_model.sv
// card model: expansion rom enable of the card in slot 1
// assumes the decoder strobes one edge after each access
`timescale 1ns/1ps
module sxd_card_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // slot signals
   input wire logic rom_sel_n,
   input wire logic strobe_n,
   input wire logic [15:0] addr,
   // expansion rom drive
   output logic rom_drive);
   logic [15:0] addr_reg;
   logic enable_reg;
   always_ff @(posedge clk) addr_reg <= addr;
   always_ff @(posedge clk)
      if (reset || (!strobe_n && addr_reg[15:8] == 8'hcf)) enable_reg <= 1'h0;
      else if (!rom_sel_n) enable_reg <= 1'h1;
   assign rom_drive = enable_reg && !strobe_n;
endmodule

// >>> test/sxd_slot_decode_test.sv
// scenario bench for the slot decoder with one card model
// assumes outputs answer one edge after each sampled access
`timescale 1ns/1ps
module sxd_slot_decode_test import sxd_pkg::*;;
   logic clk = 0, reset = 1, addr_valid = 0, rd_wr_n = 1, char_out_active = 0, expansion_window_strobe_n, rom_drive;
   logic scratch_hit, scratch_display_blank, scratch_write_block, bank2_select, bank2_read_enable;
   logic [15:0] addr = 16'h0;
   logic [7:1] slot_rom_page_select_n, slot_io_window_select_n;
   logic [2:0] scratch_slot;
   int error_cnt = 0, comparisons = 0;
   always #12.5 clk = ~clk;
   sxd_slot_decode i_dut (
      .clk(clk),
      .reset(reset),
      .addr(addr),
      .addr_valid(addr_valid),
      .rd_wr_n(rd_wr_n),
      .char_out_active(char_out_active),
      .expansion_window_strobe_n(expansion_window_strobe_n),
      .slot_rom_page_select_n(slot_rom_page_select_n),
      .slot_io_window_select_n(slot_io_window_select_n),
      .scratch_hit(scratch_hit),
      .scratch_slot(scratch_slot),
      .scratch_display_blank(scratch_display_blank),
      .scratch_write_block(scratch_write_block),
      .bank2_select(bank2_select),
      .bank2_read_enable(bank2_read_enable)
   );
   sxd_card_model i_card (
      .clk(clk),
      .reset(reset),
      .rom_sel_n(slot_rom_page_select_n[1]),
      .strobe_n(expansion_window_strobe_n),
      .addr(addr),
      .rom_drive(rom_drive)
   );
   task chk(input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task acc(input logic [15:0] a, input logic rw);
      @(posedge clk);
      {addr, addr_valid, rd_wr_n, char_out_active} <= {a, 1'h1, rw, a[0]};
      @(posedge clk);
      addr_valid <= 1'h0;
      @(negedge clk);
   endtask
   task t_exp;
      @(negedge clk);
      chk(bank2_select, 16'h0);
      acc(16'hc800, 1'h1);
      chk(rom_drive, 16'h0);
      chk(expansion_window_strobe_n, 16'h0);
      acc(16'hc100, 1'h1);
      chk(slot_rom_page_select_n, 16'h7e);
      acc(16'hc800, 1'h1);
      chk(rom_drive, 16'h1);
      acc(SXD_OWNER_SLOT_ADDR, 1'h0);
      chk(rom_drive, 16'h0);
      acc(16'hcfff, 1'h1);
      chk(expansion_window_strobe_n, 16'h0);
      acc(16'hc800, 1'h1);
      chk(rom_drive, 16'h0);
      acc(16'hc100, 1'h1);
      acc(16'hcf10, 1'h1);
      acc(16'hc800, 1'h1);
      chk(rom_drive, 16'h0);
      acc(16'hc7ff, 1'h1);
      chk(expansion_window_strobe_n, 16'h1);
      acc(16'hd000, 1'h1);
      chk(expansion_window_strobe_n, 16'h1);
      acc(SXD_BANK2_SWITCH, 1'h1);
      chk(slot_io_window_select_n, 16'h7f);
      chk(bank2_select, 16'h1);
      chk(bank2_read_enable, 16'h1);
   endtask
   task t_io;
      logic [6:0] e;
      for (int n = 1; n < 8; n++) begin
         e = ~(7'h01 << (n - 1));
         acc(16'hc08f + 16'(n * 16), 1'h1);
         chk(slot_io_window_select_n, e);
         acc(16'hc000 + 16'(n * 256), 1'h1);
         chk(slot_rom_page_select_n, e);
      end
   endtask
   task t_scr;
      for (int n = 0; n < 8; n++) begin
         acc(SXD_OWNER_SLOT_ADDR + 16'(n), 1'h0);
         chk(scratch_hit, n != 0);
         chk(scratch_slot, 16'(n));
         chk(scratch_display_blank, n != 0);
         chk(scratch_write_block, n % 2 == 1);
         acc(SXD_SCRATCH_FIRST + 16'(n * 128 + n % 7 + 1), 1'h1);
         chk(scratch_slot, 16'(n % 7 + 1));
         chk(scratch_write_block, 16'h0);
      end
      acc(16'h03ff, 1'h0);
      chk(scratch_hit, 16'h0);
      acc(16'h087f, 1'h0);
      chk(scratch_hit, 16'h0);
   endtask
   task t_rst;
      acc(16'hc100, 1'h1);
      @(posedge clk);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      @(negedge clk);
      chk(bank2_select, 16'h0);
      chk(bank2_read_enable, 16'h0);
      acc(16'hc800, 1'h1);
      chk(rom_drive, 16'h0);
   endtask
   task print_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      t_exp;
      t_io;
      t_scr;
      t_rst;
      print_verdict;
   end
endmodule
